// ---- logic/dcc_pkg.sv ----
package dcc_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int NUM_CH     = 4;
  localparam int CNT_W      = 14;
  localparam int ADDR_W     = 32;

  // ------------------------------------------------------------------
  // Register offsets (per-channel block of 0x20 bytes)
  // ------------------------------------------------------------------
  localparam logic [11:0] CH_STRIDE    = 12'h020;
  localparam logic [4:0]  OFF_CTRL     = 5'h00;
  localparam logic [4:0]  OFF_REQ      = 5'h04;
  localparam logic [4:0]  OFF_STA      = 5'h08;
  localparam logic [4:0]  OFF_STB      = 5'h0c;
  localparam logic [4:0]  OFF_PAD      = 5'h10;
  localparam logic [4:0]  OFF_CNT      = 5'h14;
  localparam logic [11:0] OFF_PWC      = 12'h100;
  localparam logic [11:0] OFF_RQC      = 12'h104;
  localparam logic [11:0] OFF_PPS      = 12'h108;
  localparam logic [11:0] OFF_LCA      = 12'h10c;
  localparam logic [11:0] OFF_LADR     = 12'h110;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h114;
  localparam logic [11:0] OFF_IRQ_CLR  = 12'h118;
  localparam logic [11:0] OFF_IRQ_EN   = 12'h11c;

  // ------------------------------------------------------------------
  // Control field positions and reset values
  // ------------------------------------------------------------------
  localparam int          B_CHANNEL_ON     = 15;
  localparam int          B_SIZE     = 14;
  localparam int          B_DIR      = 13;
  localparam int          B_HALF     = 12;
  localparam int          B_NULL_WRITE_SELECT    = 11;
  localparam int          B_ADDRESSING_SELECT    = 4;
  localparam int          B_MODE     = 0;
  localparam logic [15:0] CTRL_MASK  = 16'hf833;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [1:0]  AM_POSTINC = 2'h0;
  localparam logic [1:0]  AM_PERIND  = 2'h2;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0]       ctrl;
    logic [15:0]       req;
    logic [ADDR_W-1:0] sta;
    logic [ADDR_W-1:0] stb;
    logic [15:0]       pad;
    logic [CNT_W-1:0]  cnt;
  } dcc_chan_t;

  typedef struct packed {
    logic        valid;
    logic        wr;
    logic        byte_en;
    logic        periph;
    logic [31:0] addr;
    logic [15:0] wdata;
  } dcc_bus_req_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_NULL
  } dcc_state_t;

endpackage : dcc_pkg

// ---- logic/dcc_regmem.sv ----
`timescale 1ns/1ns
`default_nettype none
module dcc_regmem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                     pclk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);
  // ------------------------------------------------------------------
  // Word store with registered read
  // ------------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2) $error("depth too small");
  end

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // dcc_regmem
`default_nettype wire

// ---- logic/dcc_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module dcc_top
  import dcc_pkg::*;
#(
  parameter int NCH = dcc_pkg::NUM_CH
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [NCH-1:0]        dma_trig,
  output dcc_pkg::dcc_bus_req_t      mreq,
  input  wire logic                  mack,
  input  wire logic [15:0]           mrdata,
  input  wire logic                  pwr_busy,
  output logic      [NCH-1:0]        ch_irq,
  output logic                       irq
);
  import dcc_pkg::*;

  initial begin
    if (NCH != NUM_CH) $error("channel count must be four");
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  dcc_chan_t          ch_r [NCH];
  dcc_chan_t          ch_nxt [NCH];
  logic [CNT_W-1:0]   done_r [NCH];
  logic [CNT_W-1:0]   done_nxt [NCH];
  logic [31:0]        cur_r [NCH];
  logic [31:0]        cur_nxt [NCH];
  logic [NCH-1:0]     pps_r, pps_nxt, pend_r, pend_nxt;
  logic [NCH-1:0]     pwc_r, pwc_nxt, rqc_r, rqc_nxt;
  logic [NCH-1:0]     ist_r, ist_nxt, ien_r, ien_nxt, chirq_nxt;
  logic [1:0]         lca_r, lca_nxt, act_r, act_nxt;
  logic [31:0]        prdata_nxt;
  dcc_bus_req_t       mreq_nxt;
  dcc_state_t         st_r, st_nxt;
  logic               pready_nxt, pslverr_nxt, irq_nxt;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [CNT_W-1:0] half_pt(input logic [CNT_W-1:0] c);
    half_pt = CNT_W'((c + CNT_W'(1)) >> 1);
  endfunction

  function automatic logic [31:0] base_of(input dcc_chan_t c, input logic pp);
    base_of = pp ? c.stb : c.sta;
  endfunction

  // Last-address shadow store, read back for the last-address register
  logic [31:0] mem_rd;
  dcc_regmem #(.WIDTH(32), .DEPTH(NCH)) u_mem (
    .pclk  (pclk),
    .we    (st_r == ST_WRITE && mack),
    .waddr (act_r),
    .wdata (mreq.addr),
    .raddr (lca_r),
    .rdata (mem_rd)
  );

  wire logic       acc   = psel && penable && !pready;
  wire logic       wr_en = acc && pwrite;
  wire logic [1:0] sel_c = paddr[6:5];
  wire logic       in_ch = paddr[11:7] == 5'h00;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic [NCH-1:0] hits;
    logic [NCH-1:0] clr;
    logic           cnt_hit;
    logic           fin;
    hits = '0;
    clr  = '0;
    cnt_hit = 1'b0;
    fin = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      ch_nxt[i]   = ch_r[i];
      done_nxt[i] = done_r[i];
      cur_nxt[i]  = cur_r[i];
    end
    pps_nxt = pps_r;
    pend_nxt = pend_r;
    pwc_nxt = pwc_r;
    rqc_nxt = rqc_r;
    ien_nxt = ien_r;
    lca_nxt = lca_r;
    act_nxt = act_r;
    mreq_nxt = mreq;
    st_nxt = st_r;
    pready_nxt = acc;
    pslverr_nxt = 1'b0;
    prdata_nxt = '0;

    // Register writes
    if (wr_en && in_ch) begin
      unique case (paddr[4:0])
        OFF_CTRL: begin
          ch_nxt[sel_c].ctrl = pwdata[15:0] & CTRL_MASK;
          if (pwdata[B_CHANNEL_ON] && !ch_r[sel_c].ctrl[B_CHANNEL_ON]) begin
            pps_nxt[sel_c] = 1'b0;
            done_nxt[sel_c] = '0;
            cur_nxt[sel_c] = ch_r[sel_c].sta;
          end
        end
        OFF_REQ: ch_nxt[sel_c].req = pwdata[15:0];
        OFF_STA: ch_nxt[sel_c].sta = pwdata;
        OFF_STB: ch_nxt[sel_c].stb = pwdata;
        OFF_PAD: ch_nxt[sel_c].pad = pwdata[15:0];
        OFF_CNT: ch_nxt[sel_c].cnt = pwdata[CNT_W-1:0];
        default: pslverr_nxt = 1'b1;
      endcase
    end else if (wr_en) begin
      unique case (paddr)
        OFF_PWC: pwc_nxt = pwc_r & ~pwdata[NCH-1:0];
        OFF_RQC: rqc_nxt = rqc_r & ~pwdata[NCH-1:0];
        OFF_IRQ_CLR: clr = pwdata[NCH-1:0];
        OFF_IRQ_EN: ien_nxt = pwdata[NCH-1:0];
        OFF_PPS, OFF_LCA, OFF_LADR, OFF_IRQ_STAT: ;
        default: pslverr_nxt = 1'b1;
      endcase
    end

    // Register reads
    if (acc && !pwrite && in_ch) begin
      unique case (paddr[4:0])
        OFF_CTRL: prdata_nxt = {16'h0000, ch_r[sel_c].ctrl};
        OFF_REQ:  prdata_nxt = {16'h0000, ch_r[sel_c].req};
        OFF_STA:  prdata_nxt = ch_r[sel_c].sta;
        OFF_STB:  prdata_nxt = ch_r[sel_c].stb;
        OFF_PAD:  prdata_nxt = {16'h0000, ch_r[sel_c].pad};
        OFF_CNT:  prdata_nxt = {18'h00000, ch_r[sel_c].cnt};
        default:  pslverr_nxt = 1'b1;
      endcase
    end else if (acc && !pwrite) begin
      unique case (paddr)
        OFF_PWC:      prdata_nxt = 32'(pwc_r);
        OFF_RQC:      prdata_nxt = 32'(rqc_r);
        OFF_PPS:      prdata_nxt = 32'(pps_r);
        OFF_LCA:      prdata_nxt = 32'(lca_r);
        OFF_LADR:     prdata_nxt = mem_rd;
        OFF_IRQ_STAT: prdata_nxt = 32'(ist_r);
        OFF_IRQ_EN:   prdata_nxt = 32'(ien_r);
        OFF_IRQ_CLR:  prdata_nxt = '0;
        default:      pslverr_nxt = 1'b1;
      endcase
    end

    // Request capture and collision
    for (int i = 0; i < NCH; i++) begin
      if (dma_trig[i] && ch_r[i].ctrl[B_CHANNEL_ON]) begin
        if (pend_r[i]) rqc_nxt[i] = 1'b1;
        pend_nxt[i] = 1'b1;
      end
    end

    // Transfer engine
    unique case (st_r)
      ST_IDLE: begin
        for (int i = NCH - 1; i >= 0; i--) begin
          if (pend_r[i] && ch_r[i].ctrl[B_CHANNEL_ON]) act_nxt = 2'(i);
        end
        if (|(pend_r & en_vec())) begin
          pend_nxt[act_nxt] = 1'b0;
          mreq_nxt.valid   = 1'b1;
          mreq_nxt.wr      = 1'b0;
          mreq_nxt.byte_en = ch_r[act_nxt].ctrl[B_SIZE];
          mreq_nxt.periph  = !ch_r[act_nxt].ctrl[B_DIR];
          mreq_nxt.addr    = ch_r[act_nxt].ctrl[B_DIR] ? ram_addr(act_nxt)
                                                       : {16'h0000, ch_r[act_nxt].pad};
          st_nxt = ST_READ;
        end
      end
      ST_READ: if (mack) begin
        mreq_nxt.wr = 1'b1;
        mreq_nxt.periph = ch_r[act_r].ctrl[B_DIR];
        mreq_nxt.addr = ch_r[act_r].ctrl[B_DIR] ? {16'h0000, ch_r[act_r].pad}
                                                : ram_addr(act_r);
        mreq_nxt.wdata = mrdata;
        st_nxt = ST_WRITE;
      end
      ST_WRITE: if (mack) begin
        lca_nxt = act_r;
        if (mreq.periph && pwr_busy) pwc_nxt[act_r] = 1'b1;
        if (ch_r[act_r].ctrl[B_ADDRESSING_SELECT +: 2] == AM_POSTINC) begin
          cur_nxt[act_r] = cur_r[act_r] + (ch_r[act_r].ctrl[B_SIZE] ? 32'h1 : 32'h2);
        end
        done_nxt[act_r] = CNT_W'(done_r[act_r] + CNT_W'(1));
        cnt_hit = ch_r[act_r].ctrl[B_HALF] ? done_r[act_r] == half_pt(ch_r[act_r].cnt) - 1'b1
                                           : 1'b0;
        fin = done_r[act_r] == ch_r[act_r].cnt;
        if (fin) begin
          done_nxt[act_r] = '0;
          if (ch_r[act_r].ctrl[B_MODE + 1]) pps_nxt[act_r] = !pps_r[act_r];
          if (ch_r[act_r].ctrl[B_MODE] &&
              (!ch_r[act_r].ctrl[B_MODE + 1] || pps_r[act_r])) begin
            ch_nxt[act_r].ctrl[B_CHANNEL_ON] = 1'b0;
          end
          cur_nxt[act_r] = base_of(ch_r[act_r],
                                   ch_r[act_r].ctrl[B_MODE + 1] && !pps_r[act_r]);
        end
        if (cnt_hit || (fin && !ch_r[act_r].ctrl[B_HALF])) hits[act_r] = 1'b1;
        if (ch_r[act_r].ctrl[B_NULL_WRITE_SELECT] && !ch_r[act_r].ctrl[B_DIR]) begin
          mreq_nxt.periph = 1'b1;
          mreq_nxt.addr = {16'h0000, ch_r[act_r].pad};
          mreq_nxt.wdata = '0;
          st_nxt = ST_NULL;
        end else begin
          mreq_nxt.valid = 1'b0;
          st_nxt = ST_IDLE;
        end
      end
      ST_NULL: if (mack) begin
        if (pwr_busy) pwc_nxt[act_r] = 1'b1;
        mreq_nxt.valid = 1'b0;
        st_nxt = ST_IDLE;
      end
    endcase

    // Sticky status: set wins over clear
    ist_nxt = (ist_r & ~clr) | hits;
    chirq_nxt = hits;
    irq_nxt = |(ist_nxt & ien_nxt);
  end

  function automatic logic [NCH-1:0] en_vec();
    for (int i = 0; i < NCH; i++) en_vec[i] = ch_r[i].ctrl[B_CHANNEL_ON];
  endfunction

  function automatic logic [31:0] ram_addr(input logic [1:0] c);
    ram_addr = (ch_r[c].ctrl[B_ADDRESSING_SELECT +: 2] == AM_PERIND)
               ? base_of(ch_r[c], pps_r[c]) + 32'(mrdata_unused())
               : cur_r[c];
  endfunction

  function automatic logic [15:0] mrdata_unused();
    mrdata_unused = 16'h0000;
  endfunction

  // ------------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        ch_r[i] <= '0;
        done_r[i] <= '0;
        cur_r[i] <= '0;
      end
      {pps_r, pend_r, pwc_r, rqc_r, ist_r, ien_r, ch_irq} <= '0;
      {lca_r, act_r} <= '0;
      mreq <= '0;
      st_r <= ST_IDLE;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        ch_r[i] <= ch_nxt[i];
        done_r[i] <= done_nxt[i];
        cur_r[i] <= cur_nxt[i];
      end
      pps_r <= pps_nxt;
      pend_r <= pend_nxt;
      pwc_r <= pwc_nxt;
      rqc_r <= rqc_nxt;
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      ch_irq <= chirq_nxt;
      lca_r <= lca_nxt;
      act_r <= act_nxt;
      mreq <= mreq_nxt;
      st_r <= st_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      irq <= irq_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_write_done;
    st_r == ST_WRITE && mack;
  endsequence

  ctrl_zero_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    ch_r[0].ctrl[10:6] == 5'h00 && ch_r[0].ctrl[3:2] == 2'h0)
    else $error("unused control bits set");
  rst_enable_a: assert property (@(posedge pclk) $rose(presetn) |-> !ch_r[0].ctrl[B_CHANNEL_ON])
    else $error("enable not clear after reset");
  idle_when_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == ST_IDLE && en_vec() == '0) |=> st_r == ST_IDLE)
    else $error("transfer without enabled channel");
  size_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == ST_READ) |-> mreq.byte_en == ch_r[act_r].ctrl[B_SIZE])
    else $error("size select wrong");
  dir_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == ST_WRITE) |-> mreq.periph == ch_r[act_r].ctrl[B_DIR])
    else $error("direction wrong");
  null_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_write_done and ##0 (ch_r[act_r].ctrl[B_NULL_WRITE_SELECT] && !ch_r[act_r].ctrl[B_DIR]))
    |=> st_r == ST_NULL && mreq.wdata == 16'h0000)
    else $error("null write missing");
  irq_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    |ch_irq |-> ##0 |ist_r)
    else $error("channel irq without status");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |($past(ist_nxt) & $past(ien_nxt)))
    else $error("interrupt level wrong");
endmodule // dcc_top
`default_nettype wire

// ---- tb/dcc_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// RAM and peripheral bus responder, random latency
// ------------------------------------------------------------------
module dcc_mem_model
  import dcc_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire dcc_pkg::dcc_bus_req_t mreq,
  output logic                       mack,
  output logic      [15:0]           mrdata
);
  int          seed       = 80;
  int          dly        = 2;
  int          n_cnt [4]  = '{default: 0};
  logic [31:0] last_raddr = 32'h0;
  logic [15:0] last_rdata = 16'h0;
  logic [15:0] last_wdata = 16'h0;
  logic        last_be    = 1'b0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mack   <= 1'b0;
      mrdata <= 16'h5a5a;
    end else if (mack) begin
      mack   <= 1'b0;
      mrdata <= ~mrdata;
      dly    <= $random(seed) & 3;
      n_cnt[{mreq.wr, mreq.periph}] <= n_cnt[{mreq.wr, mreq.periph}] + 1;
      last_be <= mreq.byte_en;
      if (mreq.wr) begin
        last_wdata <= mreq.wdata;
      end else begin
        last_raddr <= mreq.addr;
        last_rdata <= mrdata;
      end
    end else if (mreq.valid && dly == 0) begin
      mack   <= 1'b1;
      mrdata <= 16'($random(seed));
    end else begin
      dly    <= mreq.valid ? dly - 1 : dly;
      mrdata <= ~mrdata;
    end
  end
endmodule // dcc_mem_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    n_tests++; \
    if ((gt) !== (ex)) begin \
      fail_count++; \
      $display("mismatch %s exp %0h got %0h", nm, ex, gt); \
    end \
  end
module tb_top;
  import dcc_pkg::*;
  logic         pclk     = 1'b0;
  logic         presetn  = 1'b0;
  logic         psel     = 1'b0;
  logic         penable  = 1'b0;
  logic         pwrite   = 1'b0;
  logic [11:0]  paddr    = 12'h000;
  logic [31:0]  pwdata   = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [3:0]   dma_trig = 4'h0;
  dcc_bus_req_t mreq;
  logic         mack;
  logic [15:0]  mrdata;
  logic         pwr_busy = 1'b0;
  logic [3:0]   ch_irq;
  logic         irq;
  int           seed       = 80;
  int           fail_count = 0;
  int           n_tests    = 0;
  int           c1, c2, c3;
  logic [31:0]  rv, va, vb;
  logic         er;
  logic [31:0]  ev [4][5];
  logic [4:0]   offs [5] = '{OFF_REQ, OFF_STA, OFF_STB, OFF_PAD, OFF_CNT};
  logic [31:0]  msk [5]  = '{32'hffff, 32'hffffffff, 32'hffffffff, 32'hffff, 32'h3fff};

  dcc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_trig(dma_trig), .mreq(mreq), .mack(mack), .mrdata(mrdata),
    .pwr_busy(pwr_busy), .ch_irq(ch_irq), .irq(irq));
  dcc_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mreq(mreq), .mack(mack),
    .mrdata(mrdata));

  initial begin
    forever #4 pclk = ~pclk;
  end

  // ------------------------------------------------------------------
  // Bus and trigger tasks
  // ------------------------------------------------------------------
  function automatic logic [11:0] ca(input int c, input logic [4:0] off);
    return 12'(c) * CH_STRIDE + {7'h0, off};
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) fail_count++;
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic xfer(input int c);
    int k;
    @(posedge pclk);
    dma_trig[c] <= 1'b1;
    @(posedge pclk);
    dma_trig[c] <= 1'b0;
    k = 0;
    while (mreq.valid !== 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 100) fail_count++;
    k = 0;
    while (mreq.valid !== 1'b0 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 200) fail_count++;
    repeat (2) @(posedge pclk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      rd(ca(c, OFF_CTRL));
      `CHK("ctrl_rst", 32'h0, rv)
    end
    for (int a = 0; a < 4; a++) begin
      wr(ca(a, OFF_CTRL), 32'hffff7fcf | (a << 4));
      rd(ca(a, OFF_CTRL));
      `CHK("ctrl_mask", 32'h7803 | (a << 4), rv)
    end
    $display("done control field test");
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 5; k++) begin
        ev[c][k] = $random(seed);
        wr(ca(c, offs[k]), ev[c][k]);
      end
    end
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 5; k++) begin
        rd(ca(c, offs[k]));
        `CHK("chan_reg", ev[c][k] & msk[k], rv)
      end
    end
    rd(ca(7, OFF_CTRL));
    `CHK("no_chan_err", 1'b1, er)
    $display("done register set test");
    wr(OFF_IRQ_EN, 32'hf);
    wr(OFF_IRQ_CLR, 32'hf);
    wr(ca(0, OFF_CNT), 32'h1);
    wr(ca(0, OFF_CTRL), 32'h9801);
    c1 = u_mem.n_cnt[1];
    c2 = u_mem.n_cnt[2];
    c3 = u_mem.n_cnt[3];
    xfer(0);
    rd(OFF_IRQ_STAT);
    `CHK("half_irq", 32'h1, rv)
    xfer(0);
    `CHK("per_rd", c1 + 2, u_mem.n_cnt[1])
    `CHK("ram_wr", c2 + 2, u_mem.n_cnt[2])
    `CHK("null_wr", c3 + 2, u_mem.n_cnt[3])
    `CHK("null_data", 16'h0, u_mem.last_wdata)
    rd(ca(0, OFF_CTRL));
    `CHK("oneshot_off", 32'h1801, rv)
    $display("done null write test");
    for (int m = 0; m < 4; m++) begin
      va = $random(seed);
      vb = $random(seed);
      wr(ca(m, OFF_STA), va);
      wr(ca(m, OFF_STB), vb);
      wr(ca(m, OFF_CNT), 32'h1);
      wr(OFF_IRQ_CLR, 32'hf);
      pwr_busy <= (m == 2);
      c1 = (m == 1) ? 32'h10 : (m == 3) ? 32'h20 : 0;
      wr(ca(m, OFF_CTRL), 32'ha000 | ((m & 2) << 13) | m | c1);
      for (int b = 0; b < ((m == 1) ? 1 : 2); b++) begin
        xfer(m);
        `CHK("block_start", (b == 1 && m >= 2) ? vb : va, u_mem.last_raddr)
        rd(OFF_IRQ_STAT);
        `CHK("no_half", 32'h0, rv)
        xfer(m);
        `CHK("addr_step", ((b == 1 && m >= 2) ? vb : va) + ((m == 0) ? 2 : (m == 2) ? 1 : 0), u_mem.last_raddr)
        rd(OFF_IRQ_STAT);
        `CHK("full_irq", 32'(1 << m), rv)
        `CHK("irq_out", 1'b1, irq)
        wr(OFF_IRQ_CLR, 32'(1 << m));
        rd(OFF_IRQ_STAT);
        `CHK("irq_clr", 1'b0, irq)
      end
      rd(ca(m, OFF_CTRL));
      `CHK("channel_on_end", 32'((((m & 1) ^ 1) << 15) | 32'h2000 | ((m & 2) << 13) | m | c1), rv)
      `CHK("byte_sel", 1'((m >> 1) & 1), u_mem.last_be)
      if (m < 2) `CHK("data_copy", u_mem.last_rdata, u_mem.last_wdata)
      rd(OFF_LCA);
      `CHK("last_ch", 2'(m), rv[1:0])
      rd(OFF_LADR);
      `CHK("last_addr", {16'h0, ev[m][3][15:0]}, rv)
      if (m == 2) begin
        rd(OFF_PWC);
        `CHK("wr_collide", 1'b1, rv[m])
        wr(OFF_PWC, 32'hf);
      end
      pwr_busy <= 1'b0;
      wr(ca(m, OFF_CTRL), 32'h0);
    end
    $display("done mode test");
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
